/* src/serial_frame_pkg.sv */
// constants and types for the asynchronous serial frame unit
package serial_frame_pkg;
  localparam int unsigned OVERSAMPLE    = 16;
  localparam logic [3:0]  OS_LAST       = 4'hf;
  localparam logic [3:0]  OS_HALF       = 4'h7;
  localparam logic [3:0]  OS_CLK_RISE   = 4'h8;
  localparam logic [15:0] BAUD_DIV_RST  = 16'h0043;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [2:0]  LAST_BIT_IDX  = 3'h7;
  localparam logic [1:0]  CKE_INT       = 2'h0;
  localparam logic [1:0]  CKE_INT_OUT   = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } frame_state_t;
endpackage

/* src/serial_rx_path.sv */
// receive side: start detect, centre sampling, double buffer
`timescale 1ns/1ns
`default_nettype none
module serial_rx_path
  import serial_frame_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic       i_rxd,
  input  wire logic       i_parity_en,
  input  wire logic       i_parity_odd,
  input  wire logic       i_read,
  output logic [7:0]      o_data,
  output logic            o_full,
  output logic            o_overrun,
  output logic            o_frame_err,
  output logic            o_parity_err
);
  frame_state_t state_q;
  logic [3:0]   os_q;
  logic [2:0]   bit_q;
  logic [7:0]   shift_q;
  logic         par_q;
  logic         prev_q;
  wire          fall    = prev_q & ~i_rxd;
  wire          centre  = i_tick & (os_q == OS_HALF);
  wire          done    = centre & (state_q == ST_STOP);
  wire          par_bad = i_parity_en & (par_q ^ i_parity_odd);

  always_ff @(posedge i_clk)
    if (i_rst) prev_q <= 1'b1;
    else if (i_tick) prev_q <= i_rxd;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= ST_IDLE;
      os_q    <= 4'h0;
      bit_q   <= 3'h0;
      shift_q <= DATA_RST;
      par_q   <= 1'b0;
    end
    else if (i_tick)
    begin
      os_q <= os_q + 4'h1;
      case (state_q)
        ST_IDLE:
          if (fall)
          begin
            state_q <= ST_START;
            os_q    <= 4'h1;
          end
        ST_START:
          if (centre)
          begin
            os_q    <= 4'h8;
            state_q <= i_rxd ? ST_IDLE : ST_DATA;
            bit_q   <= 3'h0;
            par_q   <= 1'b0;
          end
        ST_DATA:
          if (centre)
          begin
            shift_q <= {i_rxd, shift_q[7:1]};
            par_q   <= par_q ^ i_rxd;
            bit_q   <= bit_q + 3'h1;
            if (bit_q == LAST_BIT_IDX)
              state_q <= i_parity_en ? ST_PARITY : ST_STOP;
          end
        ST_PARITY:
          if (centre)
          begin
            par_q   <= par_q ^ i_rxd;
            state_q <= ST_STOP;
          end
        ST_STOP:
          if (centre) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // holding register; new frame wins over read
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_data       <= DATA_RST;
      o_full       <= 1'b0;
      o_overrun    <= 1'b0;
      o_frame_err  <= 1'b0;
      o_parity_err <= 1'b0;
    end
    else if (done)
    begin
      o_full       <= 1'b1;
      o_overrun    <= o_full & ~i_read;
      o_data       <= shift_q;
      o_frame_err  <= ~i_rxd;
      o_parity_err <= par_bad;
    end
    else if (i_read)
    begin
      o_full    <= 1'b0;
      o_overrun <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* src/async_serial_frame_clock.sv */
// asynchronous serial frame unit: clocking, transmitter, receiver
// Overview of operation
// - frame is low start bit, lsb-first data, optional parity, high stops.
// - transmitter and receiver run independently for full duplex.
// - both directions hold a second word so frames can run back to back.
// - mode bit and the high clock enable bit pick internal or external clock.
// - on internal clock the unit may drive a bit-rate clock out on the pin.
// - that output clock rises at the middle of each transmitted bit.
`timescale 1ns/1ns
`default_nettype none
module async_serial_frame_clock
  import serial_frame_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_comm_mode,
  input  wire logic        i_clock_enable_low,
  input  wire logic        i_clock_enable_high,
  input  wire logic [15:0] i_baud_div,
  input  wire logic        i_parity_en,
  input  wire logic        i_parity_odd,
  input  wire logic        i_two_stop,
  input  wire logic        i_tx_write,
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_rx_read,
  input  wire logic        i_sck_in,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_sck_out,
  output logic             o_sck_oe,
  output logic             o_tx_empty,
  output logic             o_tx_end,
  output logic [7:0]       o_rx_data,
  output logic             o_rx_full,
  output logic             o_rx_overrun,
  output logic             o_rx_frame_err,
  output logic             o_rx_parity_err
);
  logic [15:0]  baud_cnt_q;
  logic         sck_prev_q;
  frame_state_t tx_state_q;
  logic [3:0]   tx_os_q;
  logic [2:0]   tx_bit_q;
  logic [7:0]   tx_shift_q;
  logic [7:0]   tx_hold_q;
  logic         tx_par_q;
  logic         tx_stop2_q;

  // clock source selection
  wire [1:0] cke      = {i_clock_enable_high, i_clock_enable_low};
  wire       ext_clk  = ~i_comm_mode & cke[1];
  wire       int_tick = (baud_cnt_q == 16'h0000);
  // external 16x clock, one tick per rising edge
  wire       ext_tick = i_sck_in & ~sck_prev_q;
  wire       tick     = ext_clk ? ext_tick : int_tick;
  wire       clk_out  = ~i_comm_mode & (cke == CKE_INT_OUT);
  wire       tx_end_os = tick & (tx_os_q == OS_LAST);
  wire       tx_busy  = (tx_state_q != ST_IDLE);
  // last stop bit over, unless a second one follows
  wire       tx_stop_end = tx_end_os & (tx_state_q == ST_STOP) & ~tx_stop2_q;
  // holding word moves to the shifter
  wire       tx_load  = ~o_tx_empty & ((tick & ~tx_busy) | tx_stop_end);
  // clock falls with each new bit, rises at its middle
  wire       sck_fall = tx_load | (tx_end_os & ~tx_stop_end);
  wire       sck_rise = tick & tx_busy & (tx_os_q == OS_HALF);

  always_ff @(posedge i_clk)
    if (i_rst) baud_cnt_q <= BAUD_DIV_RST;
    else if (int_tick) baud_cnt_q <= i_baud_div;
    else baud_cnt_q <= baud_cnt_q - 16'h0001;

  always_ff @(posedge i_clk)
    if (i_rst) sck_prev_q <= 1'b0;
    else sck_prev_q <= i_sck_in;

  // bit-rate clock out, low first half, rising mid-bit
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_sck_oe  <= 1'b0;
      o_sck_out <= 1'b1;
    end
    else
    begin
      o_sck_oe  <= clk_out;
      if (sck_fall) o_sck_out <= 1'b0;
      else if (sck_rise) o_sck_out <= 1'b1;
    end
  end

  // transmit holding register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_hold_q  <= DATA_RST;
      o_tx_empty <= 1'b1;
    end
    else if (i_tx_write)
    begin
      tx_hold_q  <= i_tx_data;
      o_tx_empty <= 1'b0;
    end
    else if (tx_load)
      o_tx_empty <= 1'b1;
  end

  // transmitter, independent of receiver
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_state_q <= ST_IDLE;
      tx_os_q    <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= DATA_RST;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
      o_txd      <= 1'b1;
      o_tx_end   <= 1'b1;
    end
    else if (tick)
    begin
      if (tx_busy) tx_os_q <= tx_os_q + 4'h1;
      case (tx_state_q)
        ST_IDLE:
          if (~o_tx_empty)
          begin
            tx_shift_q <= tx_hold_q;
            tx_par_q   <= i_parity_odd;
            tx_os_q    <= 4'h0;
            tx_state_q <= ST_START;
            o_txd      <= 1'b0;
            o_tx_end   <= 1'b0;
          end
        ST_START:
          if (tx_end_os)
          begin
            tx_state_q <= ST_DATA;
            tx_bit_q   <= 3'h0;
            o_txd      <= tx_shift_q[0];
          end
        ST_DATA:
          if (tx_end_os)
          begin
            tx_par_q   <= tx_par_q ^ tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[7:1]};
            tx_bit_q   <= tx_bit_q + 3'h1;
            o_txd      <= tx_shift_q[1];
            if (tx_bit_q == LAST_BIT_IDX)
            begin
              tx_state_q <= i_parity_en ? ST_PARITY : ST_STOP;
              o_txd      <= i_parity_en ? (tx_par_q ^ tx_shift_q[0]) : 1'b1;
              tx_stop2_q <= i_two_stop;
            end
          end
        ST_PARITY:
          if (tx_end_os)
          begin
            tx_state_q <= ST_STOP;
            o_txd      <= 1'b1;
          end
        ST_STOP:
          if (tx_end_os)
          begin
            if (tx_stop2_q) tx_stop2_q <= 1'b0;
            else if (~o_tx_empty) // back to back
            begin
              tx_shift_q <= tx_hold_q;
              tx_par_q   <= i_parity_odd;
              tx_state_q <= ST_START;
              o_txd      <= 1'b0;
            end
            else
            begin
              tx_state_q <= ST_IDLE;
              o_tx_end   <= 1'b1;
            end
          end
        default: tx_state_q <= ST_IDLE;
      endcase
    end
  end

  // receiver on the same 16x tick
  serial_rx_path u_rx (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_tick       (tick),
    .i_rxd        (i_rxd),
    .i_parity_en  (i_parity_en),
    .i_parity_odd (i_parity_odd),
    .i_read       (i_rx_read),
    .o_data       (o_rx_data),
    .o_full       (o_rx_full),
    .o_overrun    (o_rx_overrun),
    .o_frame_err  (o_rx_frame_err),
    .o_parity_err (o_rx_parity_err)
  );
endmodule
`default_nettype wire

/* sim/serial_frame_checker.sv */
// port assertions for the serial frame unit
`timescale 1ns/1ns
`default_nettype none
module serial_frame_checker
  import serial_frame_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_comm_mode,
  input wire logic i_clock_enable_low,
  input wire logic i_clock_enable_high,
  input wire logic i_tx_write,
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_sck_out,
  input wire logic o_sck_oe,
  input wire logic o_tx_empty,
  input wire logic o_tx_end,
  input wire logic o_rx_full,
  input wire logic o_rx_frame_err
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  wire logic       cko;
  assign cko = !i_comm_mode
    && {i_clock_enable_high, i_clock_enable_low} == CKE_INT_OUT;
  property p_idle; o_tx_end |-> o_txd; endproperty
  a_idle: assert property (p_idle) else $error("txd low when idle");
  property p_start; $fell(o_tx_end) |-> !o_txd; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_fall; $fell(o_txd) |-> !o_tx_end; endproperty
  a_fall: assert property (p_fall) else $error("txd fell idle");
  property p_load; i_tx_write |=> !o_tx_empty; endproperty
  a_load: assert property (p_load) else $error("write not held");
  property p_oe_on; cko [*2] |-> o_sck_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("clock not out");
  property p_oe_off; !cko [*2] |-> !o_sck_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("clock out");
  property p_phase; $changed(o_txd) && !o_tx_end |-> !o_sck_out; endproperty
  a_phase: assert property (p_phase) else $error("clock phase");
  property p_rx_stop;
    $rose(o_rx_full) |-> o_rx_frame_err == !$past(i_rxd);
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("stop flag");
endmodule
bind async_serial_frame_clock serial_frame_checker i_chk (.*);
`default_nettype wire

/* sim/serial_peer.sv */
// remote serial peer: frames both ways and the 16x clock
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_per,
  input  wire logic       i_line,
  output logic            o_line,
  output logic            o_sck
);
  logic [3:0] c = 4'h0;
  initial o_line = 1'b1;
  initial o_sck = 1'b0;
  // free 16x clock, one tick per i_per cycles for i_per of 2 or more; stays low for i_per of 1
  always @(posedge i_clk)
  begin
    c <= (c >= i_per - 4'h1) ? 4'h0 : c + 4'h1;
    o_sck <= c < (i_per >> 1);
  end
  task automatic bw(input int n);
    repeat (n * i_per) @(posedge i_clk);
  endtask
  // low start, lsb first, parity, high stop
  task automatic send(input logic [7:0] d, input logic pe, input logic po);
    o_line <= 1'b0;
    bw(16);
    for (int i = 0; i < 8; i++)
    begin
      o_line <= d[i];
      bw(16);
    end
    if (pe)
    begin
      o_line <= ^d ^ po;
      bw(16);
    end
    o_line <= 1'b1;
    bw(16);
  endtask
  // start edge, then mid-bit samples of data and ninth bit
  task automatic recv(output logic [8:0] q);
    while (i_line) @(posedge i_clk);
    bw(8);
    for (int i = 0; i < 9; i++)
    begin
      bw(16);
      q[i] = i_line;
    end
    while (!i_line) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// testbench for the serial frame unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_clk, i_rst, i_comm_mode, i_clock_enable_low, i_clock_enable_high;
  logic i_parity_en, i_parity_odd, i_two_stop, i_tx_write, i_rx_read;
  logic i_sck_in, i_rxd, o_txd, o_sck_out, o_sck_oe, o_tx_empty, o_tx_end;
  logic o_rx_full, o_rx_overrun, o_rx_frame_err, o_rx_parity_err;
  logic [15:0] i_baud_div;
  logic [7:0]  i_tx_data, o_rx_data;
  logic [8:0]  q;
  logic [3:0]  per;
  int          fails = 0, checks_done = 0, cyc = 0;
  async_serial_frame_clock i_dut (.*);
  serial_peer i_peer (.i_clk, .i_per(per), .i_line(o_txd), .o_line(i_rxd),
    .o_sck(i_sck_in));
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("fails=%0d checks_done=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cfg(input logic [1:0] k, input logic [3:0] p,
    input logic [2:0] f);
    @(posedge i_clk);
    {i_clock_enable_high, i_clock_enable_low} <= k;
    per <= p;
    {i_parity_en, i_parity_odd, i_two_stop} <= f;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge i_clk);
    i_tx_data <= d;
    i_tx_write <= 1'b1;
    @(posedge i_clk);
    i_tx_write <= 1'b0;
  endtask
  task automatic rd();
    i_rx_read <= 1'b1;
    @(posedge i_clk);
    i_rx_read <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic t_duplex();
    cfg(2'h1, 4'h1, 3'h4);
    chk(o_sck_oe, 9'h1);
    wr(8'ha5);
    fork
      begin
        i_peer.recv(q);
        chk(q, 9'h0a5);
        i_peer.recv(q);
        chk(q, 9'h03c);
      end
      begin
        while (o_tx_end) @(posedge i_clk);
        wr(8'h3c);
        #1;
        chk(o_tx_empty, 9'h0);
      end
      i_peer.send(8'h96, 1'b1, 1'b0);
    join
    chk(o_rx_data, 9'h096);
    rd();
  endtask
  task automatic t_ext();
    cfg(2'h2, 4'h4, 3'h7);
    chk(o_sck_oe, 9'h0);
    wr(8'h81);
    fork
      begin
        i_peer.recv(q);
        chk(q, 9'h181);
      end
      i_peer.send(8'h5e, 1'b1, 1'b1);
    join
    chk(o_rx_data, 9'h05e);
    rd();
  endtask
  task automatic t_over();
    cfg(2'h0, 4'h1, 3'h6);
    i_peer.send(8'h11, 1'b1, 1'b1);
    i_peer.send(8'h22, 1'b1, 1'b0);
    chk({o_rx_full, o_rx_overrun, o_rx_parity_err}, 9'h7);
    rd();
    chk({o_rx_full, o_rx_overrun}, 9'h0);
  endtask
  task automatic t_ferr();
    i_comm_mode <= 1'b1;
    cfg(2'h3, 4'h1, 3'h0);
    chk(o_sck_oe, 9'h0);
    i_peer.send(8'h0f, 1'b1, 1'b0);
    chk({o_rx_full, o_rx_frame_err, o_rx_parity_err}, 9'h6);
    chk(o_rx_data, 9'h00f);
    rd();
  endtask
  initial
  begin
    i_rst = 1'b1;
    i_comm_mode = 1'b0;
    {i_clock_enable_high, i_clock_enable_low} = 2'h0;
    {i_parity_en, i_parity_odd, i_two_stop} = 3'h0;
    {i_tx_write, i_rx_read} = 2'h0;
    i_baud_div = 16'h0000;
    i_tx_data = 8'h00;
    per = 4'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({o_txd, o_sck_out, o_sck_oe, o_tx_empty, o_tx_end}, 9'h1b);
    repeat (int'(serial_frame_pkg::BAUD_DIV_RST) + 2) @(posedge i_clk);
    t_duplex();
    t_ext();
    t_over();
    t_ferr();
    end_sim();
  end
endmodule
`default_nettype wire
